// [fetch_supervisor_pkg.sv]
// constants shared by the fetch supervisor timer
package fetch_supervisor_pkg;

    // ---------------------------------------------------------------
    // widths
    // ---------------------------------------------------------------
    localparam int COUNT_W = 32;
    localparam int FUSE_W = 16;
    localparam int STEP_W = 8;

    // ---------------------------------------------------------------
    // clear sequence patterns and reset values
    // ---------------------------------------------------------------
    localparam logic [STEP_W-1:0] PRECLEAR_PATTERN = 8'h40;
    // second step pattern is a free choice; it only has to differ from the first
    localparam logic [STEP_W-1:0] CLEAR_PATTERN = 8'h08;
    localparam logic [COUNT_W-1:0] COUNT_RESET = 32'h00000000;
    localparam logic [STEP_W-1:0] STEP_RESET = 8'h00;

endpackage

// [fetch_supervisor_timer.sv]
// fetch-driven supervisory timer with two-step software clear
module fetch_supervisor_timer
    import fetch_supervisor_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // processor side
    input wire logic fetch_strobe,
    output logic timeout_irq,
    // configuration fuses
    input wire logic fuse_enable,
    input wire logic fuse_disable_setting,
    input wire logic [FUSE_W-1:0] match_value_fuse_low,
    input wire logic [FUSE_W-1:0] match_value_fuse_high,
    // supervisor_control_register enable bit
    input wire logic sw_enable_wr,
    input wire logic sw_enable_wdata,
    output logic sw_enable,
    // step field writes
    input wire logic preclear_wr,
    input wire logic [STEP_W-1:0] preclear_wdata,
    input wire logic clear_wr,
    input wire logic [STEP_W-1:0] clear_wdata,
    // status
    output logic [STEP_W-1:0] preclear_step_field,
    output logic [STEP_W-1:0] clear_step_field,
    output logic second_step_error_flag,
    output logic match_event,
    output logic [COUNT_W-1:0] count
);

    // ---------------------------------------------------------------
    // reset release
    // ---------------------------------------------------------------
    logic rst_meta_reg;
    logic rst_sync_reg;

    // two stages so release never lands near a clock edge
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    // ---------------------------------------------------------------
    // pattern decode
    // ---------------------------------------------------------------
    // one comparator shape serves both steps of the clear sequence
    function automatic logic step_pattern_hit(
        input logic [STEP_W-1:0] value,
        input logic [STEP_W-1:0] pattern
    );
        return (value == pattern);
    endfunction

    // ---------------------------------------------------------------
    // enable and match
    // ---------------------------------------------------------------
    logic [COUNT_W-1:0] match_value;
    logic active;
    logic at_match;
    logic pre_ok;
    logic clear_ok;
    logic clear_bad;
    logic count_advance;

    // high fuse word on top, low fuse word below
    assign match_value = {match_value_fuse_high, match_value_fuse_low};
    // the software bit only counts while the fuse does not forbid it
    assign active = fuse_enable | (sw_enable & ~fuse_disable_setting);
    // full-width compare, so the low half alone never fires a match
    assign at_match = (count == match_value);
    // first step is judged on the stored field, not on a write in flight
    assign pre_ok = step_pattern_hit(preclear_step_field, PRECLEAR_PATTERN);
    assign clear_ok = clear_wr && pre_ok && step_pattern_hit(clear_wdata, CLEAR_PATTERN);
    // any second step write that does not finish the sequence is a fault
    assign clear_bad = clear_wr && !clear_ok;
    // sleep simply means no fetch strobes, so the count holds by itself
    assign count_advance = active && fetch_strobe && !at_match && !match_event;

    // ---------------------------------------------------------------
    // software enable bit
    // ---------------------------------------------------------------
    logic sw_enable_next;

    // the bit is always stored; the fuse gate sits in the active decode
    always_comb begin
        sw_enable_next = sw_enable;
        if (sw_enable_wr) begin
            sw_enable_next = sw_enable_wdata;
        end
    end

    // control bit storage
    always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            sw_enable <= 1'b0;
        end else begin
            sw_enable <= sw_enable_next;
        end
    end

    // ---------------------------------------------------------------
    // fetch counter
    // ---------------------------------------------------------------
    logic [COUNT_W-1:0] count_next;

    // a valid clear outranks a fetch in the same cycle
    always_comb begin
        count_next = count;
        if (clear_ok) begin
            count_next = COUNT_RESET;
        end else if (count_advance) begin
            count_next = count + 32'h00000001;
        end
    end

    // counter storage; it never wraps because it stops at the match
    always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            count <= COUNT_RESET;
        end else begin
            count <= count_next;
        end
    end

    // ---------------------------------------------------------------
    // match event and interrupt
    // ---------------------------------------------------------------
    logic match_next;

    // sticky: a valid clear in the match cycle wins, the match re-arms later
    always_comb begin
        match_next = match_event;
        if (clear_ok) begin
            match_next = 1'b0;
        end else if (active && at_match) begin
            match_next = 1'b1;
        end
    end

    // event flag held until a valid clear or a reset
    always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            match_event <= 1'b0;
        end else begin
            match_event <= match_next;
        end
    end

    // interrupt request is its own flop so the pin comes straight from a register
    always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            timeout_irq <= 1'b0;
        end else begin
            timeout_irq <= match_next;
        end
    end

    // ---------------------------------------------------------------
    // two-step clear sequence
    // ---------------------------------------------------------------
    logic [STEP_W-1:0] preclear_next;
    logic [STEP_W-1:0] clear_field_next;
    logic error_next;

    // a wrong second step never touches the first step field
    always_comb begin
        preclear_next = preclear_step_field;
        if (clear_ok) begin
            preclear_next = STEP_RESET;
        end else if (preclear_wr) begin
            preclear_next = preclear_wdata;
        end
    end

    // second step field captures every write but a valid one, which clears it
    always_comb begin
        clear_field_next = clear_step_field;
        error_next = second_step_error_flag;
        if (clear_ok) begin
            clear_field_next = STEP_RESET;
            error_next = 1'b0;
        end else if (clear_bad) begin
            clear_field_next = clear_wdata;
            error_next = 1'b1;
        end
    end

    // first step field storage
    always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            preclear_step_field <= STEP_RESET;
        end else begin
            preclear_step_field <= preclear_next;
        end
    end

    // second step field storage
    always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            clear_step_field <= STEP_RESET;
        end else begin
            clear_step_field <= clear_field_next;
        end
    end

    // error flag: sticky, so software can spot a fault after the fact
    always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            second_step_error_flag <= 1'b0;
        end else begin
            second_step_error_flag <= error_next;
        end
    end

endmodule

// [fetch_supervisor_timer_props.sv]
// port-level checks for the fetch supervisor timer
module fetch_supervisor_timer_props
    import fetch_supervisor_pkg::*;
(
    input wire logic ref_clk, resetn, fetch_strobe, timeout_irq, fuse_enable,
    input wire logic fuse_disable_setting, sw_enable, preclear_wr, clear_wr,
    input wire logic second_step_error_flag, match_event,
    input wire logic [FUSE_W-1:0] match_value_fuse_low, match_value_fuse_high,
    input wire logic [STEP_W-1:0] preclear_step_field, clear_step_field, clear_wdata,
    input wire logic [COUNT_W-1:0] count
);
    logic en, vc;
    logic [2:0] live_pipe;
    // the design releases reset through two flops; judge only once it is live
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            live_pipe <= 3'b000;
        end else begin
            live_pipe <= {live_pipe[1:0], 1'b1};
        end
    end
    logic [COUNT_W-1:0] m;
    // a clear only counts once the first step holds its pattern
    assign vc = clear_wr && clear_wdata == CLEAR_PATTERN && preclear_step_field == PRECLEAR_PATTERN;
    assign en = fuse_enable | (sw_enable & ~fuse_disable_setting);
    assign m = {match_value_fuse_high, match_value_fuse_low};
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!live_pipe[2]);
    chk_fetch_step: assert property (
        fetch_strobe && en && !match_event && !vc && count != m |=> count == $past(count) + 1)
        else $error("count did not step on a fetch");
    chk_idle_hold: assert property (!fetch_strobe && !vc |=> $stable(count))
        else $error("count moved without a fetch");
    chk_match_raise: assert property (en && count == m && !vc |=> match_event)
        else $error("match not flagged");
    chk_irq_match: assert property (timeout_irq == match_event)
        else $error("interrupt missing on match");
    chk_match_hold: assert property (match_event && !vc |=> match_event && $stable(count))
        else $error("match state not held");
    chk_clear_good: assert property (vc |=> count == 0 && !match_event &&
        !second_step_error_flag && preclear_step_field == 0 && clear_step_field == 0)
        else $error("clear sequence did not clear");
    chk_clear_bad: assert property (clear_wr && !vc && !preclear_wr |=>
        second_step_error_flag && clear_step_field == $past(clear_wdata) &&
        $stable(preclear_step_field)) else $error("bad clear not flagged");
    chk_sw_gated: assert property (
        !fuse_enable && fuse_disable_setting && !vc |=> $stable(count))
        else $error("software enable acted while disabled");
    cover property (vc);
    cover property (match_event);
    cover property (clear_wr && !vc);
endmodule
bind fetch_supervisor_timer fetch_supervisor_timer_props props (.ref_clk, .resetn, .fetch_strobe,
    .timeout_irq, .fuse_enable, .fuse_disable_setting, .sw_enable, .preclear_wr, .clear_wr,
    .second_step_error_flag, .match_event, .match_value_fuse_low, .match_value_fuse_high,
    .preclear_step_field, .clear_step_field, .clear_wdata, .count);

// [fetch_source.sv]
// core fetch model: random fetch pattern, silent while asleep
module fetch_source (
    input wire logic ref_clk,
    input wire logic sleep,
    output logic fetch_strobe
);
    timeunit 1ns;
    timeprecision 1ps;
    int seed = 32'h3d8d;
    initial fetch_strobe = 1'b0;
    // gaps in the pattern prove the count ignores fetch-free cycles
    always @(posedge ref_clk) fetch_strobe <= #1 !sleep && ($random(seed) % 3 != 0);
endmodule

// [test_fetch_supervisor_timer.sv]
// self-checking bench for the fetch supervisor timer
module test_fetch_supervisor_timer;
    timeunit 1ns;
    timeprecision 1ps;
    import fetch_supervisor_pkg::*;
    logic ref_clk = 0, resetn = 0, sleep = 1, fuse_enable = 0, fuse_disable_setting = 1;
    logic sw_enable_wr = 0, sw_enable_wdata = 1, preclear_wr = 0, clear_wr = 0;
    logic fetch_strobe, timeout_irq, sw_enable, second_step_error_flag, match_event;
    logic [7:0] preclear_wdata = 8'h40, clear_wdata = 8'h5A, preclear_step_field, clear_step_field;
    logic [15:0] match_value_fuse_low, match_value_fuse_high = 16'h0000;
    logic [31:0] count, c0;
    int failures = 0, samples_checked = 0, seed = 32'h3d8d, i;
    always #2.5 ref_clk = ~ref_clk;
    fetch_source core (.ref_clk, .sleep, .fetch_strobe);
    fetch_supervisor_timer dut (.ref_clk, .resetn, .fetch_strobe, .timeout_irq, .fuse_enable,
        .fuse_disable_setting, .match_value_fuse_low, .match_value_fuse_high, .sw_enable_wr,
        .sw_enable_wdata, .sw_enable, .preclear_wr, .preclear_wdata, .clear_wr, .clear_wdata,
        .preclear_step_field, .clear_step_field, .second_step_error_flag, .match_event, .count);
    function logic [31:0] exp_match();
        return {match_value_fuse_high, match_value_fuse_low};
    endfunction
    task step();
        @(posedge ref_clk);
        #1;
    endtask
    task chk(logic [31:0] got, logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task end_sim();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        match_value_fuse_low = 16'h0010 + 16'($unsigned($random(seed)) % 16);
        repeat (10) step();
        resetn = 1;
        repeat (3) step();
        // software enable while the fuse forbids it
        sw_enable_wr = 1;
        step();
        sw_enable_wr = 0;
        sleep = 0;
        chk(32'(sw_enable), 1);
        repeat (20) step();
        chk(count, 0);
        fuse_disable_setting = 0;
        sw_enable_wr = 1;
        step();
        sw_enable_wr = 0;
        for (i = 0; i < 50 && count === 0; i++) step();
        sleep = 1;
        repeat (2) step();
        c0 = count;
        chk(32'(c0 == 0), 0);
        repeat (20) step();
        chk(count, c0);
        // fuse turns it on even with software locked out
        fuse_disable_setting = 1;
        fuse_enable = 1;
        sleep = 0;
        for (i = 0; i < 400 && match_event !== 1; i++) step();
        if (i == 400) begin
            failures++;
            end_sim();
        end
        chk(count, exp_match());
        chk(32'(timeout_irq), 1);
        // fetches keep coming, yet the matched count stays frozen
        repeat (5) step();
        chk(count, exp_match());
        chk(32'(match_event), 1);
        sleep = 1;
        // right second pattern without the first step is refused
        clear_wdata = CLEAR_PATTERN;
        clear_wr = 1;
        step();
        clear_wr = 0;
        step();
        chk(count, exp_match());
        chk({second_step_error_flag, clear_step_field}, {1'b1, CLEAR_PATTERN});
        // first step loaded, then a wrong second step on the next cycle
        preclear_wr = 1;
        step();
        preclear_wr = 0;
        clear_wdata = 8'h5A;
        clear_wr = 1;
        step();
        clear_wr = 0;
        step();
        chk({second_step_error_flag, clear_step_field}, 9'h15A);
        chk(preclear_step_field, PRECLEAR_PATTERN);
        // first step still stands, so the right second step now clears
        clear_wdata = CLEAR_PATTERN;
        clear_wr = 1;
        step();
        clear_wr = 0;
        step();
        chk(count, 0);
        chk({match_event, timeout_irq, second_step_error_flag}, 0);
        chk({preclear_step_field, clear_step_field}, 0);
        // let it count again, then preclear and clear on the very next cycle
        sleep = 0;
        repeat (5) step();
        sleep = 1;
        preclear_wr = 1;
        step();
        preclear_wr = 0;
        clear_wr = 1;
        step();
        clear_wr = 0;
        step();
        chk(count, 0);
        chk({match_event, second_step_error_flag, preclear_step_field}, 0);
        end_sim();
    end
endmodule
